// >>> rtl/tcc_pkg.sv
// Shared constants for the timer channel compare/capture block.
// Assumes an APB slave with byte addresses and 32-bit data.
package tcc_pkg;

   // Structure
   localparam int unsigned CH_COUNT = 2;            // Timer channels
   localparam int unsigned ADDR_W   = 8;            // APB address width
   localparam int unsigned CNT_W    = 16;           // Counter width
   localparam int unsigned CFG_W    = 6;            // Channel config width
   localparam int unsigned STAT_W   = CH_COUNT + 1; // Status and mask width

   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_MODULO  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_COUNT   = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_MASK    = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_CH_CFG  [CH_COUNT] = '{8'h14, 8'h18};
   localparam logic [ADDR_W-1:0] OFF_CH_HIGH [CH_COUNT] = '{8'h20, 8'h28};
   localparam logic [ADDR_W-1:0] OFF_CH_LOW  [CH_COUNT] = '{8'h24, 8'h2c};

   // Field positions
   localparam int unsigned CTRL_RUN  = 0;  // Counter runs
   localparam int unsigned CTRL_CLR  = 1;  // Counter clear, write only
   localparam int unsigned CFG_MSA   = 0;  // mode_select_unbuffered
   localparam int unsigned CFG_MSB   = 1;  // mode_select_buffered
   localparam int unsigned CFG_ELS   = 2;  // Edge/level select, two bits
   localparam int unsigned CFG_TOV   = 4;  // toggle_on_overflow
   localparam int unsigned CFG_FFD   = 5;  // force_full_duty
   localparam int unsigned STAT_OVF  = 0;  // overflow_flag; channel flags above

   // Reset values
   localparam logic [CNT_W-1:0]  MODULO_RST = 16'hffff;
   localparam logic [CFG_W-1:0]  CFG_RST    = 6'h00;
   localparam logic [STAT_W-1:0] MASK_RST   = 3'h0;

   // Edge/level select codes
   typedef enum logic [1:0]
   {
      ELS_OFF    = 2'b00,
      ELS_TOGGLE = 2'b01,
      ELS_CLEAR  = 2'b10,
      ELS_SET    = 2'b11
   } els_e;

   // Bus slave states
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_DONE = 2'b10
   } apb_state_e;

endpackage

// >>> rtl/timer_channel_unit.sv
// One timer channel: value register, capture, compare and pin output.
// Assumes a synchronised pin level and event pulses already gated by ce.
`timescale 1ns/100ps
module timer_channel_unit
   import tcc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // Shared counter
   input  wire logic [CNT_W-1:0] counter,
   input  wire logic             run,
   input  wire logic             ovf,
   // Configuration
   input  wire logic [CFG_W-1:0] cfg,
   // Register strobes
   input  wire logic             wr_high,
   input  wire logic             wr_low,
   input  wire logic             rd_high,
   input  wire logic             rd_low,
   input  wire logic [7:0]       wdata,
   // Pin and state
   input  wire logic             pin_sync,
   output logic      [CNT_W-1:0] value,
   output logic                  pin_level,
   output logic                  pin_oe_n,
   output logic                  event_hit,
   output logic                  match_evt
);

   els_e             els;              // Edge/level select
   logic             capture_mode;     // Input capture selected
   logic             pwm_mode;         // Output compare drives the pin
   logic             tov;              // Toggle on overflow
   logic             polarity;         // Full-duty level
   logic             rise;             // Rising edge seen
   logic             fall;             // Falling edge seen
   logic             capture_evt;      // Capture this cycle
   logic [CNT_W-1:0] next_value;
   logic             cap_lock;         // High byte read, low pending
   logic             next_cap_lock;
   logic             cmp_inhibit;      // High byte written, low pending
   logic             next_cmp_inhibit;
   logic             max_active;       // Full duty in force this period
   logic             next_max_active;
   logic             pin_prev;         // Previous synced level
   logic             next_pin_prev;
   logic             next_pin_level;
   logic             next_pin_oe_n;

   // Mode decode and events
   always_comb
   begin
      els          = els_e'(cfg[CFG_ELS +: 2]);
      tov          = cfg[CFG_TOV];
      capture_mode = !cfg[CFG_MSB] && !cfg[CFG_MSA];
      pwm_mode     = !capture_mode && (els != ELS_OFF);
      polarity     = (els != ELS_SET);
      rise         = pin_sync && !pin_prev;
      fall         = !pin_sync && pin_prev;
      // Capture blocked while the high byte waits for its low byte
      capture_evt  = ce && capture_mode && !cap_lock
                     && ((rise && els[0]) || (fall && els[1]));
      // Compare blocked between high and low byte writes
      match_evt    = ce && run && !capture_mode && !cmp_inhibit
                     && (counter == value);
      event_hit    = capture_evt || match_evt;
   end

   // Value register next state
   always_comb
   begin
      next_value = value;
      if (capture_evt)
      begin
         next_value = counter;
      end
      if (wr_high)
      begin
         next_value[15:8] = wdata;
      end
      if (wr_low)
      begin
         next_value[7:0] = wdata;
      end
   end

   // Value register has no reset
   always_ff @(posedge pclk)
   begin
      if (ce)
      begin
         value <= next_value;
      end
   end

   // Interlocks, full-duty latch and pin next state
   always_comb
   begin
      next_cap_lock    = cap_lock;
      next_cmp_inhibit = cmp_inhibit;
      // Lock follows byte order of reads
      if (rd_high && capture_mode)
      begin
         next_cap_lock = 1'b1;
      end
      if (rd_low)
      begin
         next_cap_lock = 1'b0;
      end
      // Inhibit follows byte order of writes
      if (wr_high && !capture_mode)
      begin
         next_cmp_inhibit = 1'b1;
      end
      if (wr_low)
      begin
         next_cmp_inhibit = 1'b0;
      end
      // In PWM mode full duty changes only at a period boundary
      if (!pwm_mode)
      begin
         next_max_active = 1'b0;
      end
      else if (ovf)
      begin
         next_max_active = cfg[CFG_FFD] && tov;
      end
      else
      begin
         next_max_active = max_active;
      end
      next_pin_prev = pin_sync;
      next_pin_oe_n = !pwm_mode;
      // Pin level, overflow ahead of compare
      if (els == ELS_OFF)
      begin
         next_pin_level = !cfg[CFG_MSA];
      end
      else if (capture_mode)
      begin
         next_pin_level = pin_level;
      end
      else if (max_active)
      begin
         next_pin_level = polarity;
      end
      else if (ovf && tov)
      begin
         next_pin_level = !pin_level;
      end
      else if (match_evt)
      begin
         case (els)
            ELS_TOGGLE: next_pin_level = !pin_level;
            ELS_CLEAR:  next_pin_level = 1'b0;
            ELS_SET:    next_pin_level = 1'b1;
            default:    next_pin_level = pin_level;
         endcase
      end
      else
      begin
         next_pin_level = pin_level;
      end
   end

   // Control state registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cap_lock    <= 1'b0;
         cmp_inhibit <= 1'b0;
         max_active  <= 1'b0;
         pin_prev    <= 1'b0;
         pin_level   <= 1'b1;
         pin_oe_n    <= 1'b1;
      end
      else if (ce)
      begin
         cap_lock    <= next_cap_lock;
         cmp_inhibit <= next_cmp_inhibit;
         max_active  <= next_max_active;
         pin_prev    <= next_pin_prev;
         pin_level   <= next_pin_level;
         pin_oe_n    <= next_pin_oe_n;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_tov_toggle: assert property (ce && ovf && tov && pwm_mode && !max_active
      |=> pin_level != $past(pin_level)) else $error("no toggle on overflow");
   chk_tov_off: assert property (ce && pwm_mode && !max_active && ovf && !tov
      && !match_evt |=> $stable(pin_level)) else $error("toggle without tov");
   chk_ovf_priority: assert property (ce && ovf && tov && match_evt && els == ELS_SET
      && !max_active && pin_level |=> !pin_level) else $error("compare beat overflow");
   chk_capture_idle: assert property (capture_mode |=> pin_oe_n)
      else $error("pin driven in capture");
   chk_full_level: assert property (ce && max_active && pwm_mode
      |=> pin_level == $past(polarity)) else $error("full duty level wrong");
   chk_ffd_latency: assert property (ce && pwm_mode && !ovf
      |=> max_active == $past(max_active)) else $error("full duty changed mid period");
   chk_capture_load: assert property (capture_evt && !wr_high && !wr_low
      |=> value == $past(counter)) else $error("capture value lost");
   chk_lock_holds: assert property (ce && cap_lock && !wr_high && !wr_low
      |=> value == $past(value)) else $error("capture while locked");
   chk_inhibit_holds: assert property (cmp_inhibit |-> !match_evt)
      else $error("compare while inhibited");

   cov_capture: cover property (capture_evt);
   cov_full_duty: cover property (max_active && pwm_mode);

endmodule

// >>> rtl/timer_channel_compare_capture.sv
// Timer channels with shared counter, APB register file and interrupt.
// Assumes APB master on pclk; channel pins arrive asynchronously.
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module timer_channel_compare_capture
   import tcc_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              ce,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Channel pins
   input  wire logic [CH_COUNT-1:0] channel_pin_in,
   output logic      [CH_COUNT-1:0] channel_pin_out,
   output logic      [CH_COUNT-1:0] channel_pin_oe_n,
   // Interrupt
   output logic                   irq
);

   apb_state_e        state;            // Bus slave state
   apb_state_e        next_state;
   logic              acc;              // Completing access edge
   logic              wr_en;            // Write takes effect
   logic              rd_en;            // Read takes effect
   logic              hit;              // Address is mapped
   logic [31:0]       rd_data;          // Read mux
   logic [31:0]       next_prdata;
   logic              next_pready;
   logic              next_pslverr;
   logic              run;              // Counter running
   logic              next_run;
   logic [CNT_W-1:0]  count;            // Shared counter
   logic [CNT_W-1:0]  next_count;
   logic [CNT_W-1:0]  modulo;           // Counter modulo
   logic [CNT_W-1:0]  next_modulo;
   logic              ovf_evt;          // Overflow pulse
   logic [CFG_W-1:0]  cfg      [CH_COUNT];
   logic [CFG_W-1:0]  next_cfg [CH_COUNT];
   logic [STAT_W-1:0] status;           // Sticky event flags
   logic [STAT_W-1:0] next_status;
   logic [STAT_W-1:0] mask;             // Interrupt mask
   logic [STAT_W-1:0] next_mask;
   logic              next_irq;
   logic [CNT_W-1:0]  ch_value [CH_COUNT];
   logic [CH_COUNT-1:0] ch_event;      // Capture or compare per channel
   logic [CH_COUNT-1:0] ch_match;      // Compare match per channel
   logic [CH_COUNT-1:0] pin_meta;      // First synchroniser stage
   logic [CH_COUNT-1:0] pin_sync;      // Second synchroniser stage

   // Bus strobes
   always_comb
   begin
      acc   = psel && penable && pready;
      wr_en = acc && pwrite;
      rd_en = acc && !pwrite;
   end

   // Read mux and address decode
   always_comb
   begin
      rd_data = 32'h0000_0000;
      hit     = 1'b1;
      case (paddr)
         OFF_CTRL:   rd_data[CTRL_RUN] = run;
         OFF_MODULO: rd_data[CNT_W-1:0] = modulo;
         OFF_COUNT:  rd_data[CNT_W-1:0] = count;
         OFF_STATUS: rd_data[STAT_W-1:0] = status;
         OFF_MASK:   rd_data[STAT_W-1:0] = mask;
         default:    hit = 1'b0;
      endcase
      for (int i = 0; i < CH_COUNT; i++)
      begin
         if (paddr == OFF_CH_CFG[i])
         begin
            hit = 1'b1;
            rd_data[CFG_W-1:0] = cfg[i];
         end
         if (paddr == OFF_CH_HIGH[i])
         begin
            hit = 1'b1;
            rd_data[7:0] = ch_value[i][15:8];
         end
         if (paddr == OFF_CH_LOW[i])
         begin
            hit = 1'b1;
            rd_data[7:0] = ch_value[i][7:0];
         end
      end
   end

   // Bus slave next state: one wait state, then answer
   always_comb
   begin
      next_state   = state;
      next_pready  = 1'b0;
      next_prdata  = prdata;
      next_pslverr = 1'b0;
      case (state)
         ST_IDLE:
         begin
            if (psel && penable)
            begin
               next_state   = ST_DONE;
               next_pready  = 1'b1;
               next_pslverr = !hit;
               next_prdata  = pwrite ? 32'h0000_0000 : rd_data;
            end
         end
         ST_DONE:    next_state = ST_IDLE;
         default:    next_state = ST_IDLE;
      endcase
   end

   // Counter, modulo, config, status and mask next state
   always_comb
   begin
      next_run    = run;
      next_modulo = modulo;
      next_mask   = mask;
      for (int i = 0; i < CH_COUNT; i++)
      begin
         next_cfg[i] = cfg[i];
         if (wr_en && paddr == OFF_CH_CFG[i])
         begin
            next_cfg[i] = pwdata[CFG_W-1:0];
         end
      end
      // Overflow when counter reaches modulo
      ovf_evt    = ce && run && (count == modulo);
      next_count = count;
      if (ovf_evt)
      begin
         next_count = 16'h0000;
      end
      else if (run)
      begin
         next_count = count + 16'h0001;
      end
      if (wr_en && paddr == OFF_CTRL)
      begin
         next_run = pwdata[CTRL_RUN];
         if (pwdata[CTRL_CLR])
         begin
            next_count = 16'h0000;
         end
      end
      if (wr_en && paddr == OFF_MODULO)
      begin
         next_modulo = pwdata[CNT_W-1:0];
      end
      if (wr_en && paddr == OFF_MASK)
      begin
         next_mask = pwdata[STAT_W-1:0];
      end
      // Read clears only the bits it returned; new events win
      next_status = status;
      if (rd_en && paddr == OFF_STATUS)
      begin
         next_status = status & ~prdata[STAT_W-1:0];
      end
      next_status = next_status | {ch_event, ovf_evt};
      next_irq    = |(next_status & next_mask);
   end

   // Control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state   <= ST_IDLE;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         run     <= 1'b0;
         count   <= 16'h0000;
         modulo  <= MODULO_RST;
         status  <= 3'h0;
         mask    <= MASK_RST;
         irq     <= 1'b0;
         for (int i = 0; i < CH_COUNT; i++)
         begin
            cfg[i] <= CFG_RST;
         end
      end
      else if (ce)
      begin
         state   <= next_state;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         prdata  <= next_prdata;
         run     <= next_run;
         count   <= next_count;
         modulo  <= next_modulo;
         status  <= next_status;
         mask    <= next_mask;
         irq     <= next_irq;
         cfg     <= next_cfg;
      end
   end

   // Per-channel synchroniser and channel unit
   for (genvar g = 0; g < CH_COUNT; g++)
   begin : g_ch
      // Two-stage pin synchroniser
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            pin_meta[g] <= 1'b0;
            pin_sync[g] <= 1'b0;
         end
         else if (ce)
         begin
            pin_meta[g] <= channel_pin_in[g];
            pin_sync[g] <= pin_meta[g];
         end
      end

      timer_channel_unit u_unit
      (
         .pclk      (pclk),
         .presetn   (presetn),
         .ce        (ce),
         .counter   (count),
         .run       (run),
         .ovf       (ovf_evt),
         .cfg       (cfg[g]),
         .wr_high   (wr_en && paddr == OFF_CH_HIGH[g]),
         .wr_low    (wr_en && paddr == OFF_CH_LOW[g]),
         .rd_high   (rd_en && paddr == OFF_CH_HIGH[g]),
         .rd_low    (rd_en && paddr == OFF_CH_LOW[g]),
         .wdata     (pwdata[7:0]),
         .pin_sync  (pin_sync[g]),
         .value     (ch_value[g]),
         .pin_level (channel_pin_out[g]),
         .pin_oe_n  (channel_pin_oe_n[g]),
         .event_hit (ch_event[g]),
         .match_evt (ch_match[g])
      );
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_overflow_wrap: assert property (ovf_evt && !wr_en |=> count == 16'h0000)
      else $error("counter did not restart at zero");
   chk_overflow_flag: assert property (ovf_evt |=> status[STAT_OVF])
      else $error("overflow flag not set");
   chk_compare_flag: assert property (ch_match[0] |=> status[1] ##1 status[1] || $past(rd_en))
      else $error("channel flag not set on compare");
   chk_bus_answer: assert property (psel && penable && !pready && ce |=> pready)
      else $error("slave did not answer");

   cov_overflow: cover property (ovf_evt);
   cov_irq: cover property (irq);

endmodule

// >>> test/pin_source.sv
// External source model for the channel pins.
// Assumes the bench moves the commanded level only between bus transfers.
`timescale 1ns/100ps
module pin_source
   import tcc_pkg::*;
(
   // Clock
   input  wire logic                pclk,
   // Commanded level and the driven pin
   input  wire logic [CH_COUNT-1:0] level,
   output logic      [CH_COUNT-1:0] pin
);
   // Level follows the command at a clock edge; the bench holds it many cycles
   always_ff @(posedge pclk)
   begin
      pin <= level;
   end
endmodule

// >>> test/timer_channel_compare_capture_bench.sv
// Self-checking bench: APB master, pin source, queued read checks.
// Assumes the one-wait-state APB slave and register map of tcc_pkg.
`timescale 1ns/100ps
module timer_channel_compare_capture_bench
   import tcc_pkg::*;
;
   // Expected answer of one transfer
   typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} note_s;
   logic                pclk;
   logic                presetn;
   logic                psel;
   logic                penable;
   logic                pwrite;
   logic                pready;
   logic                pslverr;
   logic                irq;
   logic [ADDR_W-1:0]   paddr;
   logic [31:0]         pwdata;
   logic [31:0]         prdata;
   logic [CH_COUNT-1:0] pin_in;
   logic [CH_COUNT-1:0] pin_out;
   logic [CH_COUNT-1:0] pin_oe_n;
   logic [CH_COUNT-1:0] drive;
   logic [CH_COUNT-1:0] ext;
   note_s               notes[$];
   note_s               nt;
   int                  fail_count;
   int                  n_checks;
   int                  tg;
   logic [15:0]         rv;

   // Wire level: device output while it drives, else the source
   assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);

   timer_channel_compare_capture dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_pin_in(pin_in),
      .channel_pin_out(pin_out), .channel_pin_oe_n(pin_oe_n), .irq(irq));
   pin_source src (.pclk(pclk), .level(drive), .pin(ext));

   // Clock
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One APB transfer; its expected answer is queued first
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic [31:0] m, input logic err);
      int n;
      notes.push_back('{exp, m, err});
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         fail_count++;
         give_verdict();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 32'hffffffff, 1'b0);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, 32'h0, e, m, 1'b0);
   endtask

   // Toggles of channel 0 pin over a window
   task automatic toggles(input int cyc, output int t);
      logic prev;
      t = 0;
      prev = pin_out[0];
      repeat (cyc)
      begin
         @(posedge pclk);
         if (pin_out[0] !== prev)
            t++;
         prev = pin_out[0];
      end
   endtask

   // Answer watcher: oldest note against each completed transfer
   always @(posedge pclk)
   begin
      if (psel && penable && pready === 1'b1)
      begin
         nt = notes.pop_front();
         check(prdata & nt.mask, nt.data);
         check(pslverr, nt.err);
      end
   end

   // Main sequence
   initial
   begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      drive = '0;
      void'($urandom(32'h660b));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFF_CTRL, 32'h0, 32'hffffffff);
      rd(OFF_MODULO, 32'hffff, 32'hffffffff);
      rd(OFF_MASK, 32'h0, 32'hffffffff);
      rd(OFF_CH_CFG[0], 32'h0, 32'hffffffff);
      rd(OFF_STATUS, 32'h0, 32'hffffffff);
      check(pin_oe_n, 2'b11);
      $display("test reset values done");
      for (int c = 0; c < CH_COUNT; c++)
      begin
         rv = 16'($urandom);
         wr(OFF_CH_HIGH[c], {24'h0, rv[15:8]});
         wr(OFF_CH_LOW[c], {24'h0, rv[7:0]});
         rd(OFF_CH_HIGH[c], {24'h0, rv[15:8]}, 32'hffffffff);
         rd(OFF_CH_LOW[c], {24'h0, rv[7:0]}, 32'hffffffff);
      end
      apb(1'b1, 8'h1c, 32'h5, 32'h0, 32'hffffffff, 1'b1);
      apb(1'b0, 8'h1c, 32'h0, 32'h0, 32'hffffffff, 1'b1);
      $display("test value registers done");
      wr(OFF_MODULO, 32'h10);
      wr(OFF_CH_CFG[0], 32'h05);
      wr(OFF_CH_HIGH[0], 32'h0);
      wr(OFF_MASK, 32'h2);
      wr(OFF_CTRL, 32'h3);
      repeat (40) @(posedge pclk);
      check(irq, 1'b0);
      wr(OFF_CTRL, 32'h0);
      rd(OFF_STATUS, 32'h1, 32'h3);
      wr(OFF_CH_LOW[0], 32'h8);
      wr(OFF_CTRL, 32'h3);
      repeat (40) @(posedge pclk);
      wr(OFF_CTRL, 32'h0);
      check(irq, 1'b1);
      rd(OFF_STATUS, 32'h3, 32'h3);
      rd(OFF_STATUS, 32'h0, 32'h7);
      @(posedge pclk);
      check(irq, 1'b0);
      $display("test compare and interrupt done");
      wr(OFF_CH_LOW[0], 32'h10);
      wr(OFF_CH_CFG[0], 32'h1d);
      wr(OFF_CTRL, 32'h3);
      check(pin_oe_n[0], 1'b0);
      repeat (40) @(posedge pclk);
      toggles(68, tg);
      check(tg, 4);
      wr(OFF_CH_CFG[0], 32'h39);
      repeat (40) @(posedge pclk);
      toggles(68, tg);
      check(tg, 0);
      check(pin_out[0], 1'b1);
      wr(OFF_CH_CFG[0], 32'h3d);
      repeat (40) @(posedge pclk);
      check(pin_out[0], 1'b0);
      wr(OFF_CH_CFG[0], 32'h1d);
      repeat (40) @(posedge pclk);
      toggles(68, tg);
      check(tg, 4);
      $display("test overflow toggle and full duty done");
      wr(OFF_CH_CFG[1], 32'h1c);
      wr(OFF_CH_HIGH[1], 32'hab);
      wr(OFF_CH_LOW[1], 32'hcd);
      repeat (10) @(posedge pclk);
      check(pin_oe_n[1], 1'b1);
      rd(OFF_CH_HIGH[1], 32'hab, 32'hffffffff);
      drive[1] <= 1'b1;
      repeat (10) @(posedge pclk);
      rd(OFF_CH_LOW[1], 32'hcd, 32'hffffffff);
      drive[1] <= 1'b0;
      repeat (10) @(posedge pclk);
      rd(OFF_CH_HIGH[1], 32'h0, 32'hffffffff);
      rd(OFF_STATUS, 32'h4, 32'h4);
      $display("test capture lock done");
      give_verdict();
   end
endmodule
